// ### rtl/input_select_pkg.sv
package input_select_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int        ADDR_W          = 8;
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int SEL_LSB     = 0;
  localparam int SEL_MSB     = 7;
  localparam int POS_LSB     = 4;
  localparam int POS_MSB     = 7;
  localparam int NEG_LSB     = 0;
  localparam int NEG_MSB     = 3;
  localparam int BURN_LSB    = 8;
  localparam int BURN_MSB    = 9;
  localparam int SCAN_BIT    = 16;

  // ==========================================================================
  // Status register fields
  // ==========================================================================
  localparam int ST_SEL_LSB   = 0;
  localparam int ST_SEL_MSB   = 7;
  localparam int ST_BURN_LSB  = 8;
  localparam int ST_BURN_MSB  = 9;
  localparam int ST_GATED_BIT = 16;
  localparam int ST_BUSY_BIT  = 17;
  localparam int ST_PEND_LSB  = 24;
  localparam int ST_PEND_MSB  = 31;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] SEL_RESET  = 8'h01;
  localparam logic [1:0] BURN_RESET = 2'h0;
  localparam logic       SCAN_RESET = 1'h0;

  // ==========================================================================
  // Selector codes
  // ==========================================================================
  localparam logic [3:0] CODE_EXT_FIRST = 4'h0;
  localparam logic [3:0] CODE_EXT_LAST  = 4'h7;
  localparam logic [3:0] CODE_GROUND    = 4'h8;
  localparam logic [3:0] CODE_ASUPPLY   = 4'h9;
  localparam logic [3:0] CODE_RESERVED  = 4'ha;
  localparam logic [3:0] CODE_REF_POS   = 4'hb;
  localparam logic [3:0] CODE_REF_NEG   = 4'hc;
  localparam logic [3:0] CODE_TEMP_P    = 4'hd;
  localparam logic [3:0] CODE_TEMP_M    = 4'he;
  localparam logic [3:0] CODE_CM_BIAS   = 4'hf;
  localparam logic [7:0] TEMP_PAIR_SEL  = 8'hde;
  localparam int         NUM_CODES      = 16;

  // ==========================================================================
  // Burnout settings
  // ==========================================================================
  localparam logic [1:0] BURN_OFF   = 2'h0;
  localparam logic [1:0] BURN_0U9   = 2'h1;
  localparam logic [1:0] BURN_3U7   = 2'h2;
  localparam logic [1:0] BURN_15U   = 2'h3;

  // ==========================================================================
  // Bus responses
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : input_select_pkg

// ### rtl/sel_decode_if.sv
`timescale 1ns/100ps
interface sel_decode_if;
  logic [3:0]  code;
  logic [15:0] onehot;
  modport ctrl (output code, input onehot);
  modport dec  (input code, output onehot);
endinterface : sel_decode_if

// ### rtl/sel_code_decoder.sv
`timescale 1ns/100ps
module sel_code_decoder
  import input_select_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  sel_decode_if.dec port_if
);

  if (NUM_CHANNELS != 2 && NUM_CHANNELS != 4 &&
      NUM_CHANNELS != 8) begin : g_bad_channels
    $error("NUM_CHANNELS must be 2, 4 or 8.");
  end

  // ==========================================================================
  // One switch per code
  // ==========================================================================
  // Unbonded channels and the reserved code close no switch at all.
  for (genvar i = 0; i < NUM_CODES; i++) begin : g_switch
    localparam logic [3:0] CODE_I = 4'(i);
    localparam bit UNBONDED = (i < 8) && (i >= NUM_CHANNELS);
    localparam bit BLOCKED  = UNBONDED || (CODE_I == CODE_RESERVED);
    assign port_if.onehot[i] = !BLOCKED && (port_if.code == CODE_I);
  end

endmodule : sel_code_decoder

// ### rtl/adc_input_select_and_burnout_ctrl.sv
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module adc_input_select_and_burnout_ctrl
  import input_select_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic              conv_start_in,
  input  wire logic              conv_busy_in,
  input  wire logic [7:0]        scan_select_in,
  output logic [15:0]            pos_switch_out,
  output logic [15:0]            neg_switch_out,
  output logic [1:0]             burnout_level_out,
  output logic                   burnout_source_en_out,
  output logic                   burnout_sink_en_out
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic              aw_got_reg,   aw_got_next;
  logic [ADDR_W-1:0] aw_addr_reg,  aw_addr_next;
  logic              w_got_reg,    w_got_next;
  logic [31:0]       w_data_reg,   w_data_next;
  logic [3:0]        w_strb_reg,   w_strb_next;
  logic              awready_reg,  awready_next;
  logic              wready_reg,   wready_next;
  logic              bvalid_reg,   bvalid_next;
  logic [1:0]        bresp_reg,    bresp_next;
  logic              arready_reg,  arready_next;
  logic              rvalid_reg,   rvalid_next;
  logic [31:0]       rdata_reg,    rdata_next;
  logic [1:0]        rresp_reg,    rresp_next;

  logic [7:0]        select_field_reg, select_field_next;
  logic [1:0]        burnout_reg,      burnout_next;
  logic              scan_mode_reg,    scan_mode_next;
  logic [7:0]        applied_sel_reg,  applied_sel_next;
  logic [15:0]       pos_sw_reg,       pos_sw_next;
  logic [15:0]       neg_sw_reg,       neg_sw_next;
  logic [1:0]        burn_lvl_reg,     burn_lvl_next;
  logic              burn_en_reg,      burn_en_next;

  logic [7:0]        pending_sel;
  logic              temp_gated;

  sel_decode_if pos_if ();
  sel_decode_if neg_if ();

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  // Only 2, 4 or 8 external channels can be bonded out.
  if (NUM_CHANNELS != 2 && NUM_CHANNELS != 4 &&
      NUM_CHANNELS != 8) begin : g_bad_channels
    $error("NUM_CHANNELS must be 2, 4 or 8.");
  end

  // ==========================================================================
  // Selector decoders
  // ==========================================================================
  sel_code_decoder #(
    .NUM_CHANNELS (NUM_CHANNELS)
  ) u_pos_decoder (
    .port_if (pos_if.dec)
  );

  sel_code_decoder #(
    .NUM_CHANNELS (NUM_CHANNELS)
  ) u_neg_decoder (
    .port_if (neg_if.dec)
  );

  // The two selectors see separate nibbles and never interact.
  assign pos_if.code = applied_sel_reg[POS_MSB:POS_LSB];
  assign neg_if.code = applied_sel_reg[NEG_MSB:NEG_LSB];

  // ==========================================================================
  // Write channel
  // ==========================================================================
  always_comb begin
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
    addr              = aw_addr_reg;
    data              = w_data_reg;
    strb              = w_strb_reg;
    aw_got_next       = aw_got_reg;
    aw_addr_next      = aw_addr_reg;
    w_got_next        = w_got_reg;
    w_data_next       = w_data_reg;
    w_strb_next       = w_strb_reg;
    bvalid_next       = bvalid_reg;
    bresp_next        = bresp_reg;
    select_field_next = select_field_reg;
    burnout_next      = burnout_reg;
    scan_mode_next    = scan_mode_reg;
    if (bvalid_reg && s_axi_bready_in) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_awvalid_in && awready_reg) begin
      aw_got_next  = 1'b1;
      aw_addr_next = s_axi_awaddr_in;
      addr         = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_reg) begin
      w_got_next  = 1'b1;
      w_data_next = s_axi_wdata_in;
      w_strb_next = s_axi_wstrb_in;
      data        = s_axi_wdata_in;
      strb        = s_axi_wstrb_in;
    end
    if (aw_got_next && w_got_next && !bvalid_reg) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      if (addr == CTRL_OFFSET) begin
        if (strb[0]) begin
          select_field_next = data[SEL_MSB:SEL_LSB];
        end
        if (strb[1]) begin
          burnout_next = data[BURN_MSB:BURN_LSB];
        end
        if (strb[2]) begin
          scan_mode_next = data[SCAN_BIT];
        end
      end else if (addr != STATUS_OFFSET) begin
        bresp_next = RESP_SLVERR;
      end
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next  = !w_got_next && !bvalid_next;
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (rvalid_reg && s_axi_rready_in) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid_in && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = 32'h0;
      rresp_next   = RESP_OKAY;
      if (s_axi_araddr_in == CTRL_OFFSET) begin
        rdata_next[SEL_MSB:SEL_LSB]   = select_field_reg;
        rdata_next[BURN_MSB:BURN_LSB] = burnout_reg;
        rdata_next[SCAN_BIT]          = scan_mode_reg;
      end else if (s_axi_araddr_in == STATUS_OFFSET) begin
        rdata_next[ST_SEL_MSB:ST_SEL_LSB]   = applied_sel_reg;
        rdata_next[ST_BURN_MSB:ST_BURN_LSB] = burn_lvl_reg;
        rdata_next[ST_GATED_BIT]            = temp_gated;
        rdata_next[ST_BUSY_BIT]             = conv_busy_in;
        rdata_next[ST_PEND_MSB:ST_PEND_LSB] = pending_sel;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
    // A new address is taken only while no read data waits.
    arready_next = !rvalid_next;
  end

  // ==========================================================================
  // Selection and burnout control
  // ==========================================================================
  assign pending_sel = scan_mode_reg ? scan_select_in
                                     : select_field_reg;
  assign temp_gated  = (applied_sel_reg == TEMP_PAIR_SEL);

  always_comb begin
    applied_sel_next = applied_sel_reg;
    if (conv_start_in) begin
      applied_sel_next = pending_sel;
    end
    pos_sw_next = pos_if.onehot;
    neg_sw_next = neg_if.onehot;
    // Burnout follows the stored setting, but is forced off while TEMP_PAIR_SEL is applied.
    burn_lvl_next = temp_gated ? BURN_OFF : burnout_reg;
    burn_en_next  = (burn_lvl_next != BURN_OFF);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Write handshake state and the settings that software stores.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      aw_got_reg       <= 1'b0;
      aw_addr_reg      <= '0;
      w_got_reg        <= 1'b0;
      w_data_reg       <= 32'h0;
      w_strb_reg       <= 4'h0;
      awready_reg      <= 1'b0;
      wready_reg       <= 1'b0;
      bvalid_reg       <= 1'b0;
      bresp_reg        <= RESP_OKAY;
      select_field_reg <= SEL_RESET;
      burnout_reg      <= BURN_RESET;
      scan_mode_reg    <= SCAN_RESET;
    end else begin
      aw_got_reg       <= aw_got_next;
      aw_addr_reg      <= aw_addr_next;
      w_got_reg        <= w_got_next;
      w_data_reg       <= w_data_next;
      w_strb_reg       <= w_strb_next;
      awready_reg      <= awready_next;
      wready_reg       <= wready_next;
      bvalid_reg       <= bvalid_next;
      bresp_reg        <= bresp_next;
      select_field_reg <= select_field_next;
      burnout_reg      <= burnout_next;
      scan_mode_reg    <= scan_mode_next;
    end
  end

  // Read handshake state.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      arready_reg      <= 1'b0;
      rvalid_reg       <= 1'b0;
      rdata_reg        <= 32'h0;
      rresp_reg        <= RESP_OKAY;
    end else begin
      arready_reg      <= arready_next;
      rvalid_reg       <= rvalid_next;
      rdata_reg        <= rdata_next;
      rresp_reg        <= rresp_next;
    end
  end

  // Applied code, switch drives and effective burnout level.
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      applied_sel_reg  <= SEL_RESET;
      pos_sw_reg       <= 16'h0;
      neg_sw_reg       <= 16'h0;
      burn_lvl_reg     <= BURN_OFF;
      burn_en_reg      <= 1'b0;
    end else begin
      applied_sel_reg  <= applied_sel_next;
      pos_sw_reg       <= pos_sw_next;
      neg_sw_reg       <= neg_sw_next;
      burn_lvl_reg     <= burn_lvl_next;
      burn_en_reg      <= burn_en_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign s_axi_awready_out     = awready_reg;
  assign s_axi_wready_out      = wready_reg;
  assign s_axi_bvalid_out      = bvalid_reg;
  assign s_axi_bresp_out       = bresp_reg;
  assign s_axi_arready_out     = arready_reg;
  assign s_axi_rvalid_out      = rvalid_reg;
  assign s_axi_rdata_out       = rdata_reg;
  assign s_axi_rresp_out       = rresp_reg;
  assign pos_switch_out        = pos_sw_reg;
  assign neg_switch_out        = neg_sw_reg;
  assign burnout_level_out     = burn_lvl_reg;
  assign burnout_source_en_out = burn_en_reg;
  assign burnout_sink_en_out   = burn_en_reg;

endmodule : adc_input_select_and_burnout_ctrl

// ### dv/input_select_checker.sv
`timescale 1ns/100ps
module input_select_checker
  import input_select_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        conv_start_in,
  input wire logic [15:0] pos_switch_out,
  input wire logic [15:0] neg_switch_out,
  input wire logic [1:0]  burnout_level_out,
  input wire logic        burnout_source_en_out,
  input wire logic        burnout_sink_en_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // ==========================================================================
  // Sequences
  // ==========================================================================
  sequence s_quiet;
    !conv_start_in [*2] ##0 !$past(sys_rst_in);
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out;
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_sel_hold: assert property (s_quiet |=>
    $stable(pos_switch_out) && $stable(neg_switch_out))
    else $error("switches moved without a conversion start");
  a_pos_onehot: assert property ($onehot0(pos_switch_out))
    else $error("more than one noninverting switch closed");
  a_neg_onehot: assert property ($onehot0(neg_switch_out))
    else $error("more than one inverting switch closed");
  a_temp_gate: assert property (
    pos_switch_out == 16'h0001 << CODE_TEMP_P &&
    neg_switch_out == 16'h0001 << CODE_TEMP_M |->
    burnout_level_out == BURN_OFF)
    else $error("burnout not gated with diode pair selected");
  a_src_sink: assert property (burnout_sink_en_out ==
    burnout_source_en_out &&
    burnout_source_en_out == (burnout_level_out != BURN_OFF))
    else $error("burnout enables disagree with level");
  a_burn_cause: assert property ($changed(burnout_level_out) |->
    $past(s_axi_bvalid_out) || $changed(pos_switch_out) ||
    $changed(neg_switch_out))
    else $error("burnout level changed without a write");
  a_write_resp: assert property (s_wr_taken |=> s_axi_bvalid_out)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
endmodule : input_select_checker

bind adc_input_select_and_burnout_ctrl input_select_checker i_chk (.*);

// ### dv/adc_input_select_and_burnout_ctrl_bench.sv
`timescale 1ns/100ps
module adc_input_select_and_burnout_ctrl_bench
  import input_select_pkg::*;
;
  logic        sys_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, src_en, snk_en;
  logic        conv_start, conv_busy, slow;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr, scan_sel;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, burn;
  logic [15:0] pos, neg;
  int          bad_count;
  int          num_checks;

  adc_input_select_and_burnout_ctrl #(.NUM_CHANNELS(8)) i_dut (
    .sys_clk_in(sys_clk), .sys_rst_in(sys_rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .conv_start_in(conv_start),
    .conv_busy_in(conv_busy), .scan_select_in(scan_sel),
    .pos_switch_out(pos), .neg_switch_out(neg),
    .burnout_level_out(burn), .burnout_source_en_out(src_en),
    .burnout_sink_en_out(snk_en));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s %h not %h", $time, msg, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] hot(input logic [3:0] c);
    return (c == CODE_RESERVED) ? 16'h0000 : 16'h0001 << c;
  endfunction : hot

  task automatic sw(input logic [3:0] p, input logic [3:0] n);
    chk({16'h0, pos}, {16'h0, hot(p)}, "pos");
    chk({16'h0, neg}, {16'h0, hot(n)}, "neg");
  endtask : sw

  task automatic bchk(input logic [1:0] b);
    chk({29'h0, burn, src_en}, {29'h0, b, b != 2'h0}, "burn");
    chk({31'h0, snk_en}, {31'h0, b != 2'h0}, "sink");
  endtask : bchk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    while (aw_p || w_p) begin
      @(posedge sys_clk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    if (slow) begin
      repeat (2) @(posedge sys_clk);
      bready <= 1'b1;
    end
    do @(posedge sys_clk); while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    if (slow) begin
      repeat (2) @(posedge sys_clk);
      rready <= 1'b1;
    end
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ed, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
  endtask : axi_rd

  task automatic conv(input logic [7:0] s, input logic busy);
    @(posedge sys_clk);
    scan_sel <= s;
    conv_busy <= busy;
    conv_start <= 1'b1;
    @(posedge sys_clk);
    conv_start <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : conv

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_codes;
    logic [3:0] c, n;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      n = (~c == CODE_RESERVED) ? c : ~c;
      if (c != CODE_RESERVED) begin
        axi_wr(CTRL_OFFSET, {24'h0, c, n}, RESP_OKAY);
        conv(8'h00, 1'b0);
        sw(c, n);
      end
    end
    axi_wr(CTRL_OFFSET, 32'h0000_0077, RESP_OKAY);
    conv(8'h00, 1'b0);
    sw(4'h7, 4'h7);
  endtask : t_codes

  task automatic t_hold;
    axi_wr(CTRL_OFFSET, 32'h0000_0023, RESP_OKAY);
    conv(8'h00, 1'b0);
    axi_wr(CTRL_OFFSET, 32'h0000_0045, RESP_OKAY);
    repeat (6) @(posedge sys_clk);
    #1;
    sw(4'h2, 4'h3);
    axi_rd(STATUS_OFFSET, 32'h4500_0023, RESP_OKAY);
    conv(8'h00, 1'b0);
    sw(4'h4, 4'h5);
  endtask : t_hold

  task automatic t_burn;
    logic [1:0] b;
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      axi_wr(CTRL_OFFSET, {22'h0, b, 8'h01}, RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      #1;
      bchk(b);
      conv(8'h00, b[0]);
      bchk(b);
    end
    axi_rd(STATUS_OFFSET, 32'h0102_0301, RESP_OKAY);
  endtask : t_burn

  task automatic t_gate;
    axi_wr(CTRL_OFFSET, 32'h0000_03de, RESP_OKAY);
    conv(8'h00, 1'b0);
    sw(CODE_TEMP_P, CODE_TEMP_M);
    bchk(BURN_OFF);
    axi_rd(CTRL_OFFSET, 32'h0000_03de, RESP_OKAY);
    axi_wr(CTRL_OFFSET, 32'h0000_0301, RESP_OKAY);
    conv(8'h00, 1'b0);
    bchk(BURN_15U);
  endtask : t_gate

  task automatic t_scan;
    axi_wr(CTRL_OFFSET, 32'h0001_0301, RESP_OKAY);
    conv(8'hb8, 1'b0);
    sw(CODE_REF_POS, CODE_GROUND);
    conv(8'hde, 1'b1);
    bchk(BURN_OFF);
    conv(8'hfc, 1'b0);
    sw(CODE_CM_BIAS, CODE_REF_NEG);
    bchk(BURN_15U);
    axi_wr(CTRL_OFFSET, 32'h0000_0301, RESP_OKAY);
    conv(8'hb8, 1'b0);
    sw(4'h0, 4'h1);
  endtask : t_scan

  task automatic t_bus;
    axi_wr(8'h08, 32'h0000_00de, RESP_SLVERR);
    axi_rd(8'h08, 32'h0000_0000, RESP_SLVERR);
    axi_wr(STATUS_OFFSET, 32'h0000_0000, RESP_OKAY);
    slow = 1'b1;
    axi_rd(CTRL_OFFSET, 32'h0000_0301, RESP_OKAY);
    wstrb <= 4'h2;
    axi_wr(CTRL_OFFSET, 32'h0001_01de, RESP_OKAY);
    axi_rd(CTRL_OFFSET, 32'h0000_0101, RESP_OKAY);
    slow = 1'b0;
    wstrb <= 4'hf;
  endtask : t_bus

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, conv_start} = 6'h00;
    {awaddr, araddr, scan_sel, wdata} = 56'h0;
    conv_busy = 1'b0;
    wstrb = 4'hf;
    slow = 1'b0;
    bad_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    sw(4'h0, 4'h1);
    bchk(BURN_OFF);
    axi_rd(CTRL_OFFSET, 32'h0000_0001, RESP_OKAY);
    t_codes();
    t_hold();
    t_burn();
    t_gate();
    t_scan();
    t_bus();
    summarize();
  end
endmodule : adc_input_select_and_burnout_ctrl_bench
